// ===== vitu_top.sv
// Vectored prioritised interrupt logic with two prescaled counter/timers and sleep control.
// Assumes all inputs synchronous to core_clk_in; the CPU sequencer pulses instr_end_in at
// the sample point of each instruction and uses the vector and push strobes driven here.
`timescale 1ns/100ps
`include "vitu_consts.svh"

// ----------------------------------------------------------------------------
// One counter/timer with its prescaler
// ----------------------------------------------------------------------------
module vitu_timer #(
  parameter int PRE_W = 6,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic             load_in,
  input  wire logic             run_in,
  input  wire logic             cont_in,
  input  wire logic [PRE_W-1:0] pre_in,
  input  wire logic [CNT_W-1:0] init_in,
  // Status
  output logic      [CNT_W-1:0] count_out,
  output logic                  done_out,
  output logic                  active_out
);
  logic [PRE_W-1:0] pre_cnt;
  logic             pre_end;
  logic             cnt_end;

  // Zero in the prescaler or counter load stands for the full range
  assign pre_end = (pre_cnt == PRE_W'(1)) || (pre_cnt == '0 && pre_in == PRE_W'(1));
  assign cnt_end = (count_out == CNT_W'(1));

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_cnt    <= '0;
      count_out  <= '0;
      active_out <= 1'b0;
      done_out   <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (load_in) begin
        pre_cnt    <= pre_in;
        count_out  <= init_in;
        active_out <= 1'b1;
      end else if (active_out && run_in && tick_in) begin
        if (pre_end) begin
          pre_cnt <= pre_in;
          if (cnt_end) begin
            done_out <= 1'b1;
            if (cont_in) begin
              count_out <= init_in;
            end else begin
              count_out  <= '0;
              active_out <= 1'b0;
            end
          end else begin
            count_out <= count_out - CNT_W'(1);
          end
        end else begin
          pre_cnt <= pre_cnt - PRE_W'(1);
        end
      end
    end
  end
endmodule // vitu_timer

// Summary of operation
// - Six maskable prioritised requests fed by eight sources.
// - Mask register enables requests together and individually.
// - Programmable priority register picks one of several pending requests.
// - Grant disables interrupts, saves counter and flags, branches through vector.
// - Six 16-bit vectors fill the lowest 12 program bytes.
// - Pending register is readable for polling.
// - Writing one to a pending bit raises that interrupt.
// - Requests sampled at instruction end; requester holds them five periods before.
// - 48 clocks prioritise and push, nine fetch vector, handler at 58.
// - Two 8-bit counters with 6-bit prescalers; second may use external source.
// - Prescale 1 to 64, count 1 to 256; request at both terminal counts.
// - Counters start, stop, continue, or restart from initial value.
// - Counter halts at zero or reloads and continues.
// - Counts readable without disturbance; prescalers not readable.
// - Second timer clock is internal divided by four or external line.
// - Timer mode sets external line as clock, triggers, or gate.
// - Timer output carries first timer, second timer, or internal clock.
// - First timer output may clock the second timer.
// - Clock-gated sleep keeps timers and requests; enabled interrupt wakes.
// - Deep sleep stops clock and oscillator; only reset ends it.
// - Mask bit six enables upper RAM guard.
// - Transmitter completion raises request shared with first timer.
// - Receiver completion raises request shared with first external line.
module vitu_top #(
  parameter int NREQ = 6
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Request sources
  input  wire logic [3:0]  ext_request_lines_in,
  input  wire logic        rx_done_in,
  input  wire logic        tx_done_in,
  input  wire logic        ext_timer_input_line_in,
  // CPU sequencer
  input  wire logic        instr_end_in,
  input  wire logic        halt_cmd_in,
  input  wire logic        stop_cmd_in,
  output logic             push_state_out,
  output logic             vector_fetch_out,
  output logic      [15:0] vector_addr_out,
  output logic             handler_fetch_out,
  output logic             cpu_clk_en_out,
  output logic             osc_run_out,
  output logic             ram_guard_out,
  // Timer output pin
  output logic             timer_out_pin_out
);
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [NREQ-1:0] pending;
  logic [7:0]      interrupt_mask_reg;
  logic [2:0]      prio;
  logic [7:0]      t0_init;
  logic [7:0]      t1_init;
  logic [7:0]      t0_pre;
  logic [7:0]      t1_pre;
  logic [7:0]      tmode;
  logic [3:0]      ext_prev;
  logic            tin_prev;
  logic [1:0]      div4;
  logic            int_tick;
  logic            trig_run;
  logic [5:0]      seq_cnt;
  logic [2:0]      grant_idx;
  logic            grant_ok;
  logic [NREQ-1:0] set_req;
  logic [NREQ-1:0] grant_clr;
  logic            sample;
  logic [7:0]      t0_count;
  logic [7:0]      t1_count;
  logic            t0_done;
  logic            t1_done;
  logic            t1_active;
  logic            t1_tick;
  logic            t1_load;
  logic            tin_rise;
  logic            wr_tm;
  vitu_pkg::vitu_ack_t   ack_state;
  vitu_pkg::vitu_sleep_t sleep_state;
  vitu_pkg::vitu_tin_t   tin_mode;

  // Trigger modes take their upper select bit from the spare bit of the first prescaler register
  assign tin_mode = vitu_pkg::vitu_tin_t'({t0_pre[`VITU_PRE_TIN_MSB], tmode[`VITU_TM_TIN_LSB]});
  assign tin_rise = ext_timer_input_line_in & ~tin_prev;
  assign wr_tm    = reg_wr_in && reg_addr_in == `VITU_ADDR_TMODE;

  // --------------------------------------------------------------------------
  // Request sources and pending register
  // --------------------------------------------------------------------------
  always_comb begin
    set_req    = '0;
    set_req[0] = ext_request_lines_in[2] & ~ext_prev[2];
    set_req[1] = ext_request_lines_in[3] & ~ext_prev[3];
    set_req[2] = ext_request_lines_in[1] & ~ext_prev[1];
    set_req[3] = (ext_request_lines_in[0] & ~ext_prev[0]) | rx_done_in;
    set_req[4] = t0_done | tx_done_in;
    set_req[5] = t1_done;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_prev <= 4'h0;
      tin_prev <= 1'b0;
    end else begin
      ext_prev <= ext_request_lines_in;
      tin_prev <= ext_timer_input_line_in;
    end
  end

  // Hardware sets win over software or grant clears
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pending <= '0;
    end else if (reg_wr_in && reg_addr_in == `VITU_ADDR_PENDING) begin
      pending <= reg_wdata_in[NREQ-1:0] | set_req;
    end else begin
      pending <= (pending & ~grant_clr) | set_req;
    end
  end

  // --------------------------------------------------------------------------
  // Priority selection
  // --------------------------------------------------------------------------
  // Priority register names the request checked first; the rest follow in rotation
  always_comb begin
    logic [NREQ-1:0] live;
    logic [2:0]      idx;
    idx       = 3'h0;
    live      = pending & interrupt_mask_reg[NREQ-1:0];
    grant_idx = 3'h0;
    grant_ok  = 1'b0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      idx = 3'((32'(prio) + i) % NREQ);
      if (live[idx]) begin
        grant_idx = idx;
        grant_ok  = 1'b1;
      end
    end
    grant_ok = grant_ok & interrupt_mask_reg[`VITU_MASK_GLOBAL];
  end

  assign sample    = instr_end_in && grant_ok && ack_state == vitu_pkg::VITU_ACK_IDLE
                     && sleep_state != vitu_pkg::VITU_SLP_STOP;
  assign grant_clr = sample ? NREQ'(1) << grant_idx : '0;

  // --------------------------------------------------------------------------
  // Acknowledge sequence
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_state         <= vitu_pkg::VITU_ACK_IDLE;
      seq_cnt           <= 6'h00;
      push_state_out    <= 1'b0;
      vector_fetch_out  <= 1'b0;
      vector_addr_out   <= `VITU_RESET_VECTOR;
      handler_fetch_out <= 1'b0;
    end else begin
      handler_fetch_out <= 1'b0;
      seq_cnt           <= seq_cnt + 6'h01;
      case (ack_state)
        vitu_pkg::VITU_ACK_IDLE: begin
          seq_cnt <= 6'h00;
          if (sample) begin
            ack_state       <= vitu_pkg::VITU_ACK_PUSH;
            push_state_out  <= 1'b1;
            vector_addr_out <= `VITU_VEC_BASE + {12'h000, grant_idx, 1'b0};
          end
        end
        vitu_pkg::VITU_ACK_PUSH: begin
          if (seq_cnt == `VITU_PUSH_CYC - 6'h01) begin
            ack_state        <= vitu_pkg::VITU_ACK_FETCH;
            push_state_out   <= 1'b0;
            vector_fetch_out <= 1'b1;
          end
        end
        vitu_pkg::VITU_ACK_FETCH: begin
          if (seq_cnt == `VITU_PUSH_CYC + `VITU_FETCH_CYC - 6'h01) begin
            ack_state        <= vitu_pkg::VITU_ACK_JUMP;
            vector_fetch_out <= 1'b0;
          end
        end
        vitu_pkg::VITU_ACK_JUMP: begin
          if (seq_cnt == `VITU_FIRST_FETCH - 6'h01) begin
            ack_state         <= vitu_pkg::VITU_ACK_IDLE;
            handler_fetch_out <= 1'b1;
          end
        end
        default: begin
          ack_state <= vitu_pkg::VITU_ACK_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_mask_reg <= `VITU_RST_BYTE;
      prio               <= 3'h0;
      t0_init            <= `VITU_RST_BYTE;
      t1_init            <= `VITU_RST_BYTE;
      t0_pre             <= `VITU_RST_BYTE;
      t1_pre             <= `VITU_RST_BYTE;
      tmode              <= `VITU_RST_BYTE;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `VITU_ADDR_MASK:    interrupt_mask_reg <= reg_wdata_in;
          `VITU_ADDR_PRIO:    prio               <= reg_wdata_in[2:0];
          `VITU_ADDR_T0_INIT: t0_init            <= reg_wdata_in;
          `VITU_ADDR_T1_INIT: t1_init            <= reg_wdata_in;
          `VITU_ADDR_T0_PRE:  t0_pre             <= reg_wdata_in;
          `VITU_ADDR_T1_PRE:  t1_pre             <= reg_wdata_in;
          `VITU_ADDR_TMODE:   tmode              <= reg_wdata_in;
          default: begin
          end
        endcase
      end
      // Grant masks further interrupts; it overrides a same-cycle mask write
      if (sample) begin
        interrupt_mask_reg[`VITU_MASK_GLOBAL] <= 1'b0;
      end
    end
  end

  // Counts read live without side effect; prescalers read as zero
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `VITU_ADDR_PENDING:  reg_rdata_out <= {2'h0, pending};
        `VITU_ADDR_MASK:     reg_rdata_out <= interrupt_mask_reg;
        `VITU_ADDR_PRIO:     reg_rdata_out <= {5'h00, prio};
        `VITU_ADDR_T0_INIT:  reg_rdata_out <= t0_init;
        `VITU_ADDR_T1_INIT:  reg_rdata_out <= t1_init;
        `VITU_ADDR_TMODE:    reg_rdata_out <= tmode;
        `VITU_ADDR_T0_COUNT: reg_rdata_out <= t0_count;
        `VITU_ADDR_T1_COUNT: reg_rdata_out <= t1_count;
        default:             reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  assign ram_guard_out = interrupt_mask_reg[`VITU_MASK_RAMGUARD];

  // --------------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div4     <= 2'h0;
      int_tick <= 1'b0;
    end else if (sleep_state != vitu_pkg::VITU_SLP_STOP) begin
      div4     <= div4 + 2'h1;
      int_tick <= (div4 == `VITU_INT_DIV);
    end else begin
      int_tick <= 1'b0;
    end
  end

  // Trigger modes hold the second timer idle until an edge on the input line
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_run <= 1'b0;
    end else if (tin_rise) begin
      trig_run <= 1'b1;
    end else if (wr_tm || (t1_done && !t1_pre[`VITU_PRE_CONT])) begin
      trig_run <= 1'b0;
    end
  end

  always_comb begin
    if (tmode[`VITU_TM_CASCADE]) begin
      t1_tick = t0_done;
    end else if (t1_pre[`VITU_PRE_T1_INT]) begin
      t1_tick = int_tick;
    end else begin
      case (tin_mode)
        vitu_pkg::VITU_TIN_CLOCK: t1_tick = tin_rise;
        vitu_pkg::VITU_TIN_GATE:  t1_tick = int_tick & ext_timer_input_line_in;
        default:                  t1_tick = int_tick & trig_run;
      endcase
    end
    t1_load = (wr_tm && reg_wdata_in[`VITU_TM_LOAD1]);
    if (!t1_pre[`VITU_PRE_T1_INT] && tin_rise &&
        (tin_mode == vitu_pkg::VITU_TIN_RETRIG ||
         (tin_mode == vitu_pkg::VITU_TIN_NRETRIG && !trig_run))) begin
      t1_load = 1'b1;
    end
  end

  vitu_timer #(.PRE_W(6), .CNT_W(8)) u_first_timer (
    .clk_in     (core_clk_in),
    .arst_n_in  (arst_n_in),
    .tick_in    (int_tick),
    .load_in    (wr_tm && reg_wdata_in[`VITU_TM_LOAD0]),
    .run_in     (tmode[`VITU_TM_RUN0]),
    .cont_in    (t0_pre[`VITU_PRE_CONT]),
    .pre_in     (t0_pre[7:2]),
    .init_in    (t0_init),
    .count_out  (t0_count),
    .done_out   (t0_done),
    .active_out ()
  );

  vitu_timer #(.PRE_W(6), .CNT_W(8)) u_second_timer (
    .clk_in     (core_clk_in),
    .arst_n_in  (arst_n_in),
    .tick_in    (t1_tick),
    .load_in    (t1_load),
    .run_in     (tmode[`VITU_TM_RUN1]),
    .cont_in    (t1_pre[`VITU_PRE_CONT]),
    .pre_in     (t1_pre[7:2]),
    .init_in    (t1_init),
    .count_out  (t1_count),
    .done_out   (t1_done),
    .active_out (t1_active)
  );

  // Output pin toggles on each terminal count of the selected timer, follows div4[1] in mode 2 and is low in mode 3
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timer_out_pin_out <= 1'b0;
    end else begin
      case (tmode[7:6])
        2'h0: timer_out_pin_out <= timer_out_pin_out ^ t0_done;
        2'h1: timer_out_pin_out <= timer_out_pin_out ^ t1_done;
        2'h2: timer_out_pin_out <= div4[1];
        default: timer_out_pin_out <= 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Sleep control
  // --------------------------------------------------------------------------
  // Sleep commands assume the sequencer already drained the pipeline
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sleep_state    <= vitu_pkg::VITU_SLP_RUN;
      cpu_clk_en_out <= 1'b1;
      osc_run_out    <= 1'b1;
    end else begin
      case (sleep_state)
        vitu_pkg::VITU_SLP_RUN: begin
          if (stop_cmd_in) begin
            sleep_state    <= vitu_pkg::VITU_SLP_STOP;
            cpu_clk_en_out <= 1'b0;
            osc_run_out    <= 1'b0;
          end else if (halt_cmd_in) begin
            sleep_state    <= vitu_pkg::VITU_SLP_HALT;
            cpu_clk_en_out <= 1'b0;
          end
        end
        vitu_pkg::VITU_SLP_HALT: begin
          if (grant_ok) begin
            sleep_state    <= vitu_pkg::VITU_SLP_RUN;
            cpu_clk_en_out <= 1'b1;
          end
        end
        vitu_pkg::VITU_SLP_STOP: begin
          sleep_state <= vitu_pkg::VITU_SLP_STOP;
        end
        default: begin
          sleep_state <= vitu_pkg::VITU_SLP_RUN;
        end
      endcase
    end
  end
endmodule // vitu_top

// ===== vitu_consts.svh
// Offsets, field positions, reset values and timing counts of the interrupt and timer unit.
// Assumes inclusion by bare name; definitions only.
`ifndef VITU_CONSTS_SVH
`define VITU_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (address port)
// ----------------------------------------------------------------------------
`define VITU_ADDR_PENDING  4'h0
`define VITU_ADDR_MASK     4'h1
`define VITU_ADDR_PRIO     4'h2
`define VITU_ADDR_T0_INIT  4'h3
`define VITU_ADDR_T1_INIT  4'h4
`define VITU_ADDR_T0_PRE   4'h5
`define VITU_ADDR_T1_PRE   4'h6
`define VITU_ADDR_TMODE    4'h7
`define VITU_ADDR_T0_COUNT 4'h8
`define VITU_ADDR_T1_COUNT 4'h9

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VITU_MASK_GLOBAL   7
`define VITU_MASK_RAMGUARD 6
`define VITU_PRE_CONT      0
`define VITU_PRE_T1_INT    1
`define VITU_PRE_TIN_MSB   1
`define VITU_TM_LOAD0      0
`define VITU_TM_RUN0       1
`define VITU_TM_LOAD1      2
`define VITU_TM_RUN1       3
`define VITU_TM_CASCADE    4
`define VITU_TM_TIN_LSB    5
`define VITU_TM_TOUT_LSB   6

// ----------------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------------
`define VITU_RST_BYTE      8'h00
`define VITU_RESET_VECTOR  16'h000C
`define VITU_VEC_BASE      16'h0000
`define VITU_INT_DIV       2'h3
`define VITU_PUSH_CYC      6'h30
`define VITU_FETCH_CYC     6'h09
`define VITU_FIRST_FETCH   6'h3A

`endif

// ===== vitu_pkg.sv
// Types of the interrupt and timer unit.
// Assumes vitu_consts.svh supplies all numeric constants.
package vitu_pkg;

  // Interrupt acknowledge sequence, Gray coded along its path
  typedef enum logic [1:0] {
    VITU_ACK_IDLE  = 2'h0,
    VITU_ACK_PUSH  = 2'h1,
    VITU_ACK_FETCH = 2'h3,
    VITU_ACK_JUMP  = 2'h2
  } vitu_ack_t;

  typedef enum logic [1:0] {
    VITU_SLP_RUN  = 2'h0,
    VITU_SLP_HALT = 2'h1,
    VITU_SLP_STOP = 2'h3
  } vitu_sleep_t;

  // External timer input use
  typedef enum logic [1:0] {
    VITU_TIN_CLOCK   = 2'h0,
    VITU_TIN_GATE    = 2'h1,
    VITU_TIN_NRETRIG = 2'h2,
    VITU_TIN_RETRIG  = 2'h3
  } vitu_tin_t;

endpackage

// ===== vitu_checker.sv
// Port-level assertions for the interrupt and timer unit.
// Assumes a bind onto vitu_top; sees only its ports.
`timescale 1ns/100ps
module vitu_checker (
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        arst_n_in,
  // Register port and sequencer commands
  input wire logic [3:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        halt_cmd_in,
  input wire logic        stop_cmd_in,
  // Acknowledge and sleep outputs
  input wire logic        push_state_out,
  input wire logic        vector_fetch_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic        handler_fetch_out,
  input wire logic        cpu_clk_en_out,
  input wire logic        osc_run_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_push_length: assert property ($rose(push_state_out) |-> ##48 (!push_state_out && vector_fetch_out))
    else $error("push phase length wrong");
  a_fetch_length: assert property ($rose(vector_fetch_out) |-> ##8 vector_fetch_out ##1 !vector_fetch_out)
    else $error("vector fetch length wrong");
  a_handler_after: assert property ($fell(vector_fetch_out) |=> handler_fetch_out ##1 !handler_fetch_out)
    else $error("handler fetch not one pulse after vector fetch");
  a_vector_slot: assert property ($rose(push_state_out) |-> vector_addr_out < 16'h000C && !vector_addr_out[0])
    else $error("vector outside table");
  a_stop_holds: assert property (!osc_run_out |=> !osc_run_out)
    else $error("deep sleep left without reset");
  a_stop_enter: assert property (stop_cmd_in |=> !osc_run_out && !cpu_clk_en_out)
    else $error("deep sleep not entered");
  a_halt_enter: assert property (halt_cmd_in && !stop_cmd_in && osc_run_out |=> !cpu_clk_en_out && osc_run_out)
    else $error("clock-gated sleep wrong");
  a_pre_hidden: assert property (reg_rd_in && (reg_addr_in == 4'h5 || reg_addr_in == 4'h6)
    |=> reg_rdata_out == 8'h00) else $error("prescaler readable");
  c_grant: cover property ($rose(push_state_out));
  c_handler: cover property (handler_fetch_out);
  c_stop: cover property ($fell(osc_run_out));
endmodule // vitu_checker

// ===== vitu_cpu_model.sv
// Behavioural CPU sequencer: marks the end of every eight-cycle instruction.
// Assumes the unit's clock enable gates it, so a sleeping core samples nothing.
`timescale 1ns/100ps
module vitu_cpu_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Unit side
  input  wire logic cpu_clk_en_in,
  output logic      instr_end_out
);
  logic [2:0] phase;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) phase <= 3'h0;
    else if (cpu_clk_en_in) phase <= phase + 3'h1;
  end
  // Sample point only while the core clock runs
  assign instr_end_out = (phase == 3'h7) && cpu_clk_en_in;
endmodule // vitu_cpu_model

// ===== test_vectored_interrupt_and_timer_unit.sv
// Self-checking bench of the interrupt and timer unit.
// Assumes vitu_top, vitu_cpu_model and vitu_checker are compiled first.
`timescale 1ns/100ps
module test_vectored_interrupt_and_timer_unit;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rx = 1'b0, tx = 1'b0, tin = 1'b0, hc = 1'b0, sc = 1'b0;
  logic [3:0]  addr = 4'h0, ext = 4'h0;
  logic [7:0]  wd = 8'h00, rdat;
  logic        ie, push, vf, hf, cen, osc, rg, tout;
  logic [15:0] va;
  int          fails = 0, checked = 0;
  always #2 clk = ~clk;
  vitu_cpu_model cpu (.clk_in(clk), .arst_n_in(rst_n), .cpu_clk_en_in(cen), .instr_end_out(ie));
  vitu_top dut (.core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdat), .ext_request_lines_in(ext), .rx_done_in(rx), .tx_done_in(tx),
    .ext_timer_input_line_in(tin), .instr_end_in(ie), .halt_cmd_in(hc), .stop_cmd_in(sc), .push_state_out(push),
    .vector_fetch_out(vf), .vector_addr_out(va), .handler_fetch_out(hf), .cpu_clk_en_out(cen),
    .osc_run_out(osc), .ram_guard_out(rg), .timer_out_pin_out(tout));
  task automatic give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk({8'h00, rdat}, {8'h00, e});
  endtask
  // 0 grant, 1 handler fetch, 2 core clock back
  task automatic wait_on(input int s);
    int n;
    n = 0;
    while (!(s == 0 ? push === 1'b1 : s == 1 ? hf === 1'b1 : cen === 1'b1)) begin
      @(posedge clk); #1 n++;
      if (n > 200) begin
        chk(16'h0000, 16'h0001);
        give_verdict();
      end
    end
  endtask
  task automatic t_reset;
    #1 chk(va, 16'h000C);
    chk({osc, cen}, 16'h0003);
    rd_reg(4'h1, 8'h00);
    rd_reg(4'hF, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_soft;
    wr_reg(4'h2, 8'h03);
    wr_reg(4'h0, 8'h14);
    wr_reg(4'h1, 8'hEF);
    wait_on(0);
    chk(va, 16'h0004);
    chk({15'h0, rg}, 16'h0001);
    rd_reg(4'h0, 8'h10);
    rd_reg(4'h1, 8'h6F);
    wait_on(1);
    wr_reg(4'h0, 8'h00);
    $display("software request test done");
  endtask
  task automatic t_poll;
    wr_reg(4'h1, 8'h00);
    @(posedge clk); ext <= 4'h2; rx <= 1'b1;
    @(posedge clk); rx <= 1'b0; tx <= 1'b1;
    @(posedge clk); tx <= 1'b0; ext <= 4'h0;
    rd_reg(4'h0, 8'h1C);
    wr_reg(4'h0, 8'h00);
    $display("poll test done");
  endtask
  task automatic t_timer;
    wr_reg(4'h3, 8'h03);
    wr_reg(4'h5, 8'h04);
    wr_reg(4'h7, 8'h03);
    repeat (60) @(posedge clk);
    rd_reg(4'h8, 8'h00);
    rd_reg(4'h8, 8'h00);
    rd_reg(4'h5, 8'h00);
    rd_reg(4'h0, 8'h10);
    chk({15'h0000, tout}, 16'h0001);
    wr_reg(4'h0, 8'h00);
    $display("timer test done");
  endtask
  task automatic t_second;
    wr_reg(4'h3, 8'h01);
    wr_reg(4'h5, 8'h05);
    wr_reg(4'h4, 8'h02);
    wr_reg(4'h6, 8'h04);
    wr_reg(4'h7, 8'h1F);
    repeat (40) @(posedge clk);
    rd_reg(4'h9, 8'h00);
    rd_reg(4'h0, 8'h30);
    wr_reg(4'h4, 8'h03);
    wr_reg(4'h7, 8'h0C);
    repeat (2) begin
      @(posedge clk); tin <= 1'b1;
      @(posedge clk); tin <= 1'b0;
    end
    rd_reg(4'h9, 8'h01);
    wr_reg(4'h4, 8'h02);
    wr_reg(4'h6, 8'h06);
    wr_reg(4'h7, 8'h0C);
    repeat (20) @(posedge clk);
    rd_reg(4'h9, 8'h00);
    wr_reg(4'h7, 8'h00);
    wr_reg(4'h0, 8'h00);
    $display("second timer test done");
  endtask
  task automatic t_sleep;
    wr_reg(4'h1, 8'h81);
    // Sequencer has flushed with a no-operation before this command
    @(posedge clk); hc <= 1'b1;
    @(posedge clk); hc <= 1'b0;
    #1 chk({osc, cen}, 16'h0002);
    wr_reg(4'h0, 8'h01);
    wait_on(2);
    wait_on(1);
    @(posedge clk); sc <= 1'b1;
    @(posedge clk); sc <= 1'b0;
    #1 chk({osc, cen}, 16'h0000);
    @(posedge clk); rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({osc, va[14:0]}, 16'h800C);
    $display("sleep test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_soft();
    t_poll();
    t_timer();
    t_second();
    t_sleep();
    give_verdict();
  end
endmodule // test_vectored_interrupt_and_timer_unit
bind vitu_top vitu_checker u_chk (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .halt_cmd_in(halt_cmd_in), .stop_cmd_in(stop_cmd_in),
  .push_state_out(push_state_out), .vector_fetch_out(vector_fetch_out), .vector_addr_out(vector_addr_out),
  .handler_fetch_out(handler_fetch_out), .cpu_clk_en_out(cpu_clk_en_out), .osc_run_out(osc_run_out));
